// ### design/window_watchdog_core.sv
/*
  window watchdog core: 7-bit free-running downcounter with prescaler,
  activation flag, window compare and reset pulse generator.
  assumes synchronous option and power-mode inputs from the same clock,
  a wishbone classic master, and that the reset pulse feeds system reset.
*/
module window_watchdog_core
  import wwdg_pkg::*;
#(
  parameter int step_cycles = step_cycles_default  // shorten in simulation
)
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // options and power modes
  input  wire config_type     config_in,
  input  wire power_ctrl_type power_in,
  // reset request
  output logic             reset_pin_n,   // low while reset pulse runs
  output logic             reset_request  // one pulse per watchdog reset
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic               activation, next_activation;    // software flag
  logic [6:0]         counter, next_counter;          // timeout_count_field
  logic [6:0]         window, next_window;            // window limit
  logic [31:0]        prescaler, next_prescaler;      // step divider
  wd_state_type       state, next_state;              // halt tracking
  logic               halt_step, next_halt_step;      // one step on halt
  logic [12:0]        start_count, next_start_count;  // wake delay
  logic [31:0]        pulse_count, next_pulse_count;  // reset pulse width
  logic               pin_n, next_pin_n;
  logic               req, next_req;
  logic [31:0]        rdata, next_rdata;
  logic               ack, next_ack;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic access;       // new request this cycle
  logic wr_control;   // control write, low byte lane
  logic wr_window;    // window write
  logic active;       // watchdog may reset
  logic step;         // prescaler tick
  logic counting;     // counter may move
  logic fire;         // any reset cause

  always_comb
  begin
    access     = cyc_i && stb_i && !ack;
    wr_control = access && we_i && sel_i[0] && adr_i == control_offset;
    wr_window  = access && we_i && sel_i[0] && adr_i == window_offset;
    active     = activation || config_in.hardware_watchdog;
    counting   = state == wd_run || halt_step;
    step       = prescaler == 32'(step_cycles - 1);
  end

  // ----------------------------------------------------------------
  // counter, flag, window and halt sequencing
  // ----------------------------------------------------------------
  // next values for all watchdog state
  always_comb
  begin
    next_activation  = activation;
    next_counter     = counter;
    next_window      = window;
    next_prescaler   = prescaler;
    next_state       = state;
    next_halt_step   = 1'b0;
    next_start_count = start_count;
    fire             = 1'b0;
    // prescaler runs in run state; phase unknown to software on writes
    if (counting)
      next_prescaler = step ? 32'h0 : prescaler + 32'h1;
    // decrement even when inactive, and once on halt entry unless oscillator_interrupt_enable is set
    if (counting && (step || halt_step))
    begin
      next_counter = counter - 7'h01;
      if (active && counter == counter_threshold && state == wd_run)
        fire = 1'b1;
    end
    if (wr_control)
    begin
      next_counter = dat_i[6:0];
      if (dat_i[activation_bit])
        next_activation = 1'b1;
      if (active && counter > window)
        fire = 1'b1;
      if (active && !dat_i[top_bit])
        fire = 1'b1;           // software reset via cleared top bit
    end
    if (wr_window)
      next_window = dat_i[6:0];
    case (state)
      wd_run:
      begin
        if (power_in.halt_request)
        begin
          if (config_in.oscillator_interrupt_enable)
            next_state = wd_halted;
          else if (config_in.halt_reset_option)
            fire = active;
          else
          begin
            next_state     = wd_halted;
            next_halt_step = 1'b1;
          end
        end
      end
      wd_halted:
      begin
        // no reset is fired from here; counter is frozen after any halt-entry step
        if (config_in.oscillator_interrupt_enable &&
            (power_in.wake_interrupt || power_in.wake_oscillator))
          next_state = wd_run;
        else if (power_in.wake_interrupt || power_in.wake_reset)
        begin
          next_state       = wd_startup;
          next_start_count = config_in.long_startup ?
                             13'(long_start_clocks - 1) : 13'(short_start_clocks - 1);
          if (power_in.wake_reset && !config_in.oscillator_interrupt_enable)
          begin
            next_activation = 1'b0;
            next_counter    = control_reset[6:0];
            next_window     = window_reset;
          end
        end
      end
      wd_startup:
      begin
        if (start_count == 13'h0000)
          next_state = wd_run;
        else
          next_start_count = start_count - 13'h0001;
      end
      default: next_state = wd_run;
    endcase
  end

  // registers for watchdog state
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      activation  <= control_reset[activation_bit];
      counter     <= control_reset[6:0];
      window      <= window_reset;
      prescaler   <= 32'h0;
      state       <= wd_run;
      halt_step   <= 1'b0;
      start_count <= 13'h0000;
    end
    else
    begin
      activation  <= next_activation;
      counter     <= next_counter;
      window      <= next_window;
      prescaler   <= next_prescaler;
      state       <= next_state;
      halt_step   <= next_halt_step;
      start_count <= next_start_count;
    end
  end

  // ----------------------------------------------------------------
  // reset pulse generator
  // ----------------------------------------------------------------
  // retrigger-free: a running pulse absorbs further causes
  always_comb
  begin
    next_pulse_count = pulse_count;
    next_pin_n       = pin_n;
    next_req         = 1'b0;
    if (pulse_count != 32'h0)
    begin
      next_pulse_count = pulse_count - 32'h1;
      if (pulse_count == 32'h1)
        next_pin_n = 1'b1;
    end
    else if (fire)
    begin
      next_pulse_count = 32'(pulse_cycles);
      next_pin_n       = 1'b0;
      next_req         = 1'b1;
    end
  end

  // pulse registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pulse_count <= 32'h0;
      pin_n       <= 1'b1;
      req         <= 1'b0;
    end
    else
    begin
      pulse_count <= next_pulse_count;
      pin_n       <= next_pin_n;
      req         <= next_req;
    end
  end

  // ----------------------------------------------------------------
  // wishbone read and acknowledge
  // ----------------------------------------------------------------
  // one wait state: ack one edge after request, dropped the edge after
  always_comb
  begin
    next_ack   = access;
    next_rdata = 32'h0;
    if (access && !we_i)
    begin
      case (adr_i)
        control_offset: next_rdata = {24'h0, activation, counter};
        window_offset:  next_rdata = {25'h0, window};
        status_offset:  next_rdata = {28'h0, ~pin_n, active, 2'(state)};
        default:        next_rdata = 32'h0;   // unmapped reads zero
      endcase
    end
  end

  // bus registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ack   <= 1'b0;
      rdata <= 32'h0;
    end
    else
    begin
      ack   <= next_ack;
      rdata <= next_rdata;
    end
  end

  assign ack_o         = ack;
  assign dat_o         = rdata;
  assign reset_pin_n   = pin_n;
  assign reset_request = req;

endmodule : window_watchdog_core

// ### common/wwdg_pkg.sv
/*
  package for the window watchdog core: register offsets, field positions,
  reset values, timing counts and the carrier structs.
  assumes a 100 MHz system clock and a classic wishbone register bus.
*/
package wwdg_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [3:0] control_offset     = 4'h0;  // watchdog_control
  localparam logic [3:0] window_offset      = 4'h4;  // window_limit_register
  localparam logic [3:0] status_offset      = 4'h8;  // read-only block state
  localparam int         activation_bit     = 7;     // flag position
  localparam int         top_bit            = 6;     // downcounter_top_bit
  localparam logic [7:0] control_reset      = 8'h7F;
  localparam logic [6:0] window_reset       = 7'h7F;
  localparam logic [6:0] counter_threshold  = 7'h40;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int clock_mhz           = 100;
  localparam int osc2_mhz            = 8;    // secondary oscillator rate
  localparam int osc2_per_step       = 16384;
  // system cycles per decrement step, osc2 cycles scaled to clk
  localparam int step_cycles_default = osc2_per_step * clock_mhz / osc2_mhz;
  localparam int pulse_time_ns       = 30000;   // reset pulse width
  localparam int pulse_cycles        = pulse_time_ns * clock_mhz / 1000;
  localparam int short_start_clocks  = 256;
  localparam int long_start_clocks   = 4096;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       halt_request;   // halt instruction executing, one pulse
    logic       wake_interrupt; // external interrupt wake, one pulse
    logic       wake_oscillator;// oscillator interrupt wake, one pulse
    logic       wake_reset;     // halt ended by a reset, one pulse
    logic       slow_mode;      // informational, no effect
    logic       wait_mode;      // informational, no effect
  } power_ctrl_type;

  typedef struct packed {
    logic       hardware_watchdog;           // option: always active
    logic       halt_reset_option;           // option: reset on halt
    logic       long_startup;                // 1: 4096 clocks, 0: 256
    logic       oscillator_interrupt_enable; // selects active-halt
    logic [1:0] timebase_select;             // clock controller timebase
  } config_type;

  typedef enum logic [1:0] { wd_run, wd_halted, wd_startup } wd_state_type;

endpackage : wwdg_pkg

// ### test/wwdg_port_checker.sv
/*
  port checker for window_watchdog_core: handshake, reset pulse shape,
  halt reset and the quiet disabled state.
  assumes it is bound into every instance of the core.
*/
module wwdg_port_checker
  import wwdg_pkg::*;
#(
  parameter int step_cycles = 8  // kept in step with the core
)
(
  // clock and reset
  input wire logic           clk,
  input wire logic           reset,
  // wishbone
  input wire logic           cyc_i,
  input wire logic           stb_i,
  input wire logic           we_i,
  input wire logic [3:0]     adr_i,
  input wire logic [3:0]     sel_i,
  input wire logic [31:0]    dat_i,
  input wire logic [31:0]    dat_o,
  input wire logic           ack_o,
  // options, power, reset out
  input wire config_type     config_in,
  input wire power_ctrl_type power_in,
  input wire logic           reset_pin_n,
  input wire logic           reset_request
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------
  // helper state
  // ----------------
  logic [15:0] low_cnt;  // cycles the pin has been low
  logic        armed;    // activation written since reset
  // too long a pulse is counted, not unrolled
  always_ff @(posedge clk)
  begin
    low_cnt <= (reset || reset_pin_n) ? 16'h0 : low_cnt + 16'h1;
    armed   <= !reset && (armed || (cyc_i && stb_i && we_i && !ack_o && sel_i[0]
               && adr_i == control_offset && dat_i[activation_bit]));
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // pin stays low, request stays single
  sequence held_low;
    (!reset_request && !reset_pin_n) [*8];
  endsequence
  // ----------------
  // properties
  // ----------------
  a_ack_follows: assert property ((cyc_i && stb_i && !ack_o) |=> ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_pulse_start: assert property ($fell(reset_pin_n) |-> reset_request)
    else $error("pin low without request");
  a_pulse_hold: assert property (reset_request |-> !reset_pin_n ##1 held_low)
    else $error("reset pulse shape wrong");
  a_pulse_width: assert property ($rose(reset_pin_n) |-> low_cnt == 16'(pulse_cycles))
    else $error("reset pulse width wrong");
  a_halt_reset: assert property ((power_in.halt_request && config_in.halt_reset_option
    && config_in.hardware_watchdog && !config_in.oscillator_interrupt_enable && reset_pin_n)
    |=> reset_request) else $error("halt did not reset");
  a_disabled_quiet: assert property ((!armed && !config_in.hardware_watchdog)
    |-> !reset_request) else $error("reset while disabled");
  a_unmapped_zero: assert property ((cyc_i && stb_i && !we_i && !ack_o && adr_i == 4'hC)
    |=> dat_o == 32'h0) else $error("unmapped read not zero");
endmodule : wwdg_port_checker

bind window_watchdog_core wwdg_port_checker #(.step_cycles(step_cycles)) u_check (
  .clk(clk), .reset(reset), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .config_in(config_in),
  .power_in(power_in), .reset_pin_n(reset_pin_n), .reset_request(reset_request));

// ### test/testbench.sv
/*
  self-checking bench for window_watchdog_core over wishbone.
  assumes the core runs with a short step of 8 clocks.
*/
module testbench
  import wwdg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------
  // signals
  // ----------------
  logic           clk = 1'b0;    // 100 MHz
  logic           reset = 1'b1;  // held at start
  logic           cyc = 1'b0;
  logic           stb = 1'b0;
  logic           we = 1'b0;
  logic [3:0]     adr = 4'h0;
  logic [31:0]    dat = 32'h0;
  config_type     cfg = '0;      // option levels
  power_ctrl_type pwr = '0;      // power pulses
  logic [31:0]    rdat;
  logic           ack;
  logic           pin_n;
  logic           req;
  logic [7:0]     q;             // last read byte
  logic [7:0]     h;             // count held for compare
  int             fail_count = 0;
  int             samples_checked = 0;
  int             cycles = 0;
  int             pulses = 0;    // watchdog resets seen
  initial
  begin
    forever #5 clk = ~clk;
  end
  window_watchdog_core #(.step_cycles(8)) DUT (
    .clk(clk), .reset(reset), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(4'hF), .dat_i(dat), .dat_o(rdat), .ack_o(ack), .config_in(cfg),
    .power_in(pwr), .reset_pin_n(pin_n), .reset_request(req));
  // ----------------
  // tasks
  // ----------------
  task automatic results;
    if (fail_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // prescaler phase is unknown, so counts are bounded
  task automatic rng(input string n, input logic [7:0] lo, hi, g);
    samples_checked++;
    if (!(g >= lo && g <= hi) || $isunknown(g))
    begin
      fail_count++;
      $display("MISMATCH %s expected %h..%h seen %h", n, lo, hi, g);
    end
  endtask : rng
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // classic cycle: hold until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, 24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat[7:0];
    {cyc, stb, we} <= 3'h0;
  endtask : wb
  task automatic poke(input power_ctrl_type p);
    @(posedge clk);
    pwr <= p;
    @(posedge clk);
    pwr <= '0;
  endtask : poke
  task automatic hard_reset;
    reset <= 1'b1;
    tick(16);
    reset <= 1'b0;
  endtask : hard_reset
  // pulse count and hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (req === 1'b1) pulses++;
    if (cycles == 20000)
    begin
      fail_count++;
      results();
    end
  end
  // ----------------
  // sequence
  // ----------------
  initial
  begin
    tick(16);
    reset <= 1'b0;
    wb(0, control_offset, 8'h0); chk("control", control_reset, q);
    wb(0, window_offset, 8'h0); chk("window", {1'b0, window_reset}, q);
    wb(0, 4'hC, 8'h0); chk("unmapped", 8'h00, q);
    wb(1, control_offset, 8'h7F); tick(40);
    wb(0, control_offset, 8'h0); rng("count", 8'h78, 8'h7B, q);
    tick(600); chk("quiet", 8'h00, 8'(pulses));
    wb(1, control_offset, 8'hFF); wb(1, control_offset, 8'h7F);
    wb(0, control_offset, 8'h0); chk("active", 8'h80, q & 8'h80);
    wb(1, window_offset, 8'h50); wb(1, control_offset, 8'hFF);
    tick(2); chk("early", 8'h01, 8'(pulses));
    // status while the pulse runs: pin low and active, state bits masked off
    wb(0, status_offset, 8'h0);
    chk("status", 8'h0C, q & 8'h0C);
    tick(3100); hard_reset();
    wb(0, control_offset, 8'h0); chk("cleared", control_reset, q);
    wb(1, control_offset, 8'hC2); tick(4); chk("pending", 8'h01, 8'(pulses));
    tick(26); chk("timeout", 8'h02, 8'(pulses));
    // reset lands after the pulse ends but before the wrapped count fires again
    tick(3020); hard_reset();
    cfg <= config_type'{hardware_watchdog: 1'b1, halt_reset_option: 1'b1, default: '0};
    poke(power_ctrl_type'{halt_request: 1'b1, default: 1'b0});
    tick(2); chk("halt reset", 8'h03, 8'(pulses));
    tick(3100); cfg <= '0; hard_reset();
    wb(1, control_offset, 8'h7F);
    poke(power_ctrl_type'{halt_request: 1'b1, default: 1'b0});
    tick(200); wb(0, control_offset, 8'h0); rng("halted", 8'h7D, 8'h7E, q);
    h = q; poke(power_ctrl_type'{wake_interrupt: 1'b1, default: 1'b0}); tick(200);
    wb(0, control_offset, 8'h0); chk("startup", h, q);
    tick(300); wb(0, control_offset, 8'h0); rng("resumed", h - 8'h22, h - 8'h1D, q);
    // halt while active, then a reset wake must restore the disabled state
    wb(1, control_offset, 8'hFF);
    poke(power_ctrl_type'{halt_request: 1'b1, default: 1'b0});
    poke(power_ctrl_type'{wake_reset: 1'b1, default: 1'b0});
    tick(4);
    wb(0, control_offset, 8'h0);
    chk("reset wake", control_reset, q);
    // let the startup delay run out before the next halt request
    tick(300);
    cfg <= config_type'{oscillator_interrupt_enable: 1'b1, default: '0};
    wb(1, control_offset, 8'h7F);
    poke(power_ctrl_type'{halt_request: 1'b1, default: 1'b0});
    tick(200); wb(0, control_offset, 8'h0); rng("frozen", 8'h7E, 8'h7F, q);
    h = q; poke(power_ctrl_type'{wake_oscillator: 1'b1, default: 1'b0}); tick(40);
    wb(0, control_offset, 8'h0); rng("woken", h - 8'h06, h - 8'h04, q);
    results();
  end
endmodule : testbench
